/* hw/snp_pkg.sv */
// package: opcodes, field layout, timing
// assumes a 250 MHz core clock; host sets the serial clock
package snp_pkg;

   // core clock period and internal operation times
   localparam int CLK_PERIOD_PS   = 4000;
   localparam int PROGRAM_TIME_NS = 200;
   localparam int ERASE_TIME_NS   = 1000;
   // least times round up to whole cycles
   localparam int PROGRAM_CYCLES  = (PROGRAM_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ERASE_CYCLES    = (ERASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BUSY_W          = 12;

   // instruction codes understood by the decoder
   localparam logic [7:0] OPC_READ_STATUS = 8'h05;
   localparam logic [7:0] OPC_DUAL_READ   = 8'h3B;
   localparam logic [7:0] OPC_QUAD_READ   = 8'h6B;
   localparam logic [7:0] OPC_QUAD_LOAD   = 8'h32;
   localparam logic [7:0] OPC_WRITE_PROT  = 8'h1F;
   localparam logic [7:0] OPC_PROGRAM     = 8'h10;
   localparam logic [7:0] OPC_ERASE       = 8'hD8;

   // protection_reg layout
   localparam int         PROT_GUARD_MODE_BIT = 7;
   localparam int         PROT_BLOCK_LSB      = 3;
   localparam int         PROT_LOCK_LSB       = 1;
   localparam logic [7:0] PROT_RESET          = 8'h00;

   // blocks in the array
   localparam logic [8:0] BLOCK_COUNT = 9'h100;

   // frame phases of the link side
   typedef enum logic [2:0] {
      PH_OPCODE  = 3'b000,
      PH_ARG     = 3'b001,
      PH_QUAD_IN = 3'b010,
      PH_OUT     = 3'b011,
      PH_IGNORE  = 3'b100
   } snp_phase_e;

   // output lane count
   typedef enum logic [1:0] {
      LW_ONE  = 2'b00,
      LW_TWO  = 2'b01,
      LW_FOUR = 2'b10
   } snp_width_e;

   // request from link to core at deselect
   typedef struct packed {
      logic       valid;
      logic [7:0] code;
      logic [7:0] arg;
   } snp_req_s;

   // slow state from core to link
   typedef struct packed {
      logic       armed;
      logic       guardMode;
      logic [7:0] status;
      logic [7:0] buffer;
   } snp_cfg_s;

endpackage

/* hw/snp_sync.sv */
// two-flop level synchroniser for a vector of quasi-static bits
// assumes the bits settle long before use, so skew is harmless
`timescale 1ns/1ps
module snp_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,   // destination clock
   input  wire logic             rst,   // synchronous reset, active high
   input  wire logic [WIDTH-1:0] din,   // asynchronous level in
   output logic      [WIDTH-1:0] dout   // synchronised level out
);
   logic [WIDTH-1:0] meta_q;   // first stage, read only by second stage

   // two stages, nothing taps the first
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

/* hw/snp_pause.sv */
// pause tracker on the serial clock
// assumes frameRst is high while deselected
`timescale 1ns/1ps
module snp_pause (
   input  wire logic sclk,        // host serial clock
   input  wire logic frameRst,    // async frame reset
   input  wire logic pauseN,      // pause pin, active low
   input  wire logic quadActive,  // pin is a data lane, no pause
   output logic      pauseAtRise, // pause state held over the high phase
   output logic      pauseNow     // pause state right now
);
   // state captured as the clock rises; while the clock is high a change of
   // the pin counts from the next fall
   always_ff @(posedge sclk or posedge frameRst) begin
      if (frameRst) begin
         pauseAtRise <= 1'b0;
      end else begin
         pauseAtRise <= ~pauseN & ~quadActive;  // [RULE_19] [RULE_20]
      end
   end

   // clock low: pin acts at once; high: held value
   assign pauseNow = ~quadActive & (sclk ? pauseAtRise : ~pauseN);  // [RULE_19] [RULE_20] [RULE_17]
endmodule

/* hw/snp_nand_if.sv */
// pin-level host interface of a serial nand flash: select gating, single,
// dual and quad lanes, write-guard pin and pause pin
// assumes the host drives sclk (mode 0 or 3); the core runs on clk
//
// Summary of operation
// RULE_01: deselected means every output lane floats
// RULE_02: internal operations finish despite deselect
// RULE_03: ignore instructions until first select falling edge
// RULE_04: single-lane input sampled on rising clock
// RULE_05: single-lane output updates on falling clock
// RULE_06: dual/quad lanes: rise samples, fall drives
// RULE_07: standard/dual use lanes 0-1; quad all four
// RULE_08: guard and pause only outside quad operation
// RULE_09: guard_pin_mode chooses software or hardware protection
// RULE_10: software mode: pin guards protection_reg, quad lane
// RULE_11: hardware mode: pin is dedicated guard input
// RULE_12: hardware mode, pin low: all writes rejected
// RULE_13: guard_pin_mode set refuses quad reads
// RULE_14: guard bits protect one block up to all
// RULE_15: pause floats output, ignores input and clock
// RULE_16: after pause, resume from held state
// RULE_17: quad read/load: pause pin is lane3
// RULE_18: host drives pause pin high when idle
// RULE_19: pause begins on pin fall if clock low
// RULE_20: pause ends on pin rise if clock low
// RULE_21: host keeps select low during pause
// RULE_22: clock modes 0 and 3 supported
// RULE_23: partial instruction at deselect is discarded
`timescale 1ns/1ps
module snp_nand_if
   import snp_pkg::*;
(
   input  wire logic       clk,           // core clock, 250 MHz
   input  wire logic       srst,          // synchronous reset, active high
   input  wire logic       sclk,          // host serial clock
   input  wire logic       selectN,       // select pin, active low
   input  wire logic [3:0] laneIn,        // pin levels: 0 serial_in, 2 write_guard_n, 3 pause_n
   output logic      [3:0] laneOut,       // lane drive values, 1 is serial_out
   output logic      [3:0] laneOeN,       // lane output enables, low drives
   output logic            opBusy,        // internal operation running
   output logic      [7:0] protectionReg, // protection register contents
   output logic            cmdRejected    // last deselected command was refused
);

   // link side state (sclk domain)
   logic       frameRst;       // async clear of frame state
   snp_phase_e phase_q;        // frame phase
   logic [2:0] bitCnt_q;       // bit position in current byte
   logic [7:0] shiftIn_q;      // input shift register
   logic [7:0] code_q;         // decoded opcode of this frame
   snp_width_e width_q;        // output lane width
   logic       srcBuf_q;       // output source: buffer or status
   logic       quadActive_q;   // lanes 2 and 3 are data
   logic       started_q;      // a rise seen this frame
   snp_req_s   req_q;          // request for the core
   logic [7:0] outShift_q;     // output shift register
   logic [2:0] outCnt_q;       // output bit position
   logic       pauseAtRise;    // pause state over the high phase
   logic       pauseNow;       // pause state now
   logic       floatNow;       // force all lanes to float
   logic       pausedRise;     // rising edge falls inside a pause
   logic       argDone;        // argument byte complete on this edge
   logic [7:0] argByte;        // completed argument byte
   logic [7:0] opcNow;         // opcode completed on this edge
   snp_cfg_s   cfgL;           // core state seen by the link

   // output datapath, combinational
   logic [2:0] outStep;        // bits per falling edge
   logic [3:0] outMask;        // lanes used for output
   logic [7:0] outNext;        // next output shift value
   logic [3:0] outLanes;       // lane values from outNext

   // core side state (clk domain)
   logic [1:0]        pinSync;    // synced select, guard
   logic              selS;       // select level
   logic              guardS;     // write guard level
   logic              selPrev_q;  // select level one cycle ago
   logic              armed_q;    // a select falling edge has been seen
   snp_req_s          reqS;       // synchronised request
   logic [7:0]        buffer_q;   // page buffer byte
   logic [BUSY_W-1:0] busyCnt_q;  // remaining busy cycles
   logic              execute;    // taken at deselect
   logic              accept;     // passes protection
   logic              startOp;    // launch an operation
   logic [BUSY_W-1:0] opLen;      // its length
   logic              guardMode;  // guard_pin_mode bit
   logic [3:0]        blockBits;  // block_guard_bits field
   logic              lockBit;    // register_lock_bits low bit
   logic [8:0]        guardCount; // guarded blocks
   logic              inRegion;   // block argument is guarded
   snp_cfg_s          cfgC;       // core state for the link

   // deselect or reset clears frame state
   assign frameRst = selectN | srst;  // [RULE_23] [RULE_21]

   // pause pin pauses only outside quad
   snp_pause u_pause (
      .sclk        (sclk),
      .frameRst    (frameRst),
      .pauseN      (laneIn[3]),
      .quadActive  (quadActive_q),
      .pauseAtRise (pauseAtRise),
      .pauseNow    (pauseNow)
   );

   // a rise sees the low-phase pin: pause is the pin level
   assign pausedRise = ~laneIn[3] & ~quadActive_q;  // [RULE_08] [RULE_15]
   assign floatNow   = frameRst | pauseNow;          // [RULE_01] [RULE_15]

   // core state crosses as slow levels
   snp_sync #(.WIDTH($bits(snp_cfg_s))) u_cfg_sync (
      .clk  (sclk),
      .rst  (1'b0),
      .din  (cfgC),
      .dout (cfgL)
   );

   // byte completion on this rise
   always_comb begin
      opcNow  = {shiftIn_q[6:0], laneIn[0]};
      argDone = 1'b0;
      argByte = opcNow;
      if (phase_q == PH_ARG && bitCnt_q == 3'h7) begin
         argDone = 1'b1;
      end else if (phase_q == PH_QUAD_IN && bitCnt_q == 3'h4) begin
         argDone = 1'b1;
         argByte = {shiftIn_q[3:0], laneIn};  // nibble on all four lanes [RULE_07]
      end
   end

   // input shift and decode on the rise
   always_ff @(posedge sclk or posedge frameRst) begin
      if (frameRst) begin
         phase_q      <= PH_OPCODE;   // partial byte is thrown away [RULE_23]
         bitCnt_q     <= 3'h0;
         shiftIn_q    <= 8'h00;
         code_q       <= 8'h00;
         width_q      <= LW_ONE;
         srcBuf_q     <= 1'b0;
         quadActive_q <= 1'b0;
         started_q    <= 1'b0;
      end else if (!pausedRise) begin  // clock ignored while paused [RULE_15] [RULE_16]
         started_q <= 1'b1;
         case (phase_q)
            PH_OPCODE: begin
               shiftIn_q <= opcNow;                    // [RULE_04] [RULE_22]
               bitCnt_q  <= bitCnt_q + 3'h1;
               if (bitCnt_q == 3'h7) begin
                  code_q <= opcNow;
                  if (!cfgL.armed) begin
                     phase_q <= PH_IGNORE;             // [RULE_03]
                  end else begin
                     case (opcNow)
                        OPC_READ_STATUS: begin
                           phase_q <= PH_OUT;
                           width_q <= LW_ONE;
                        end
                        OPC_DUAL_READ: begin
                           phase_q  <= PH_OUT;
                           width_q  <= LW_TWO;         // [RULE_07]
                           srcBuf_q <= 1'b1;
                        end
                        OPC_QUAD_READ: begin
                           if (cfgL.guardMode) begin
                              phase_q <= PH_IGNORE;    // [RULE_13] [RULE_11]
                           end else begin
                              phase_q      <= PH_OUT;
                              width_q      <= LW_FOUR;
                              srcBuf_q     <= 1'b1;
                              quadActive_q <= 1'b1;    // [RULE_17] [RULE_10]
                           end
                        end
                        OPC_QUAD_LOAD: begin
                           if (cfgL.guardMode) begin
                              phase_q <= PH_IGNORE;    // pin is no data lane [RULE_11]
                           end else begin
                              phase_q      <= PH_QUAD_IN;
                              quadActive_q <= 1'b1;    // [RULE_17]
                           end
                        end
                        OPC_WRITE_PROT, OPC_PROGRAM, OPC_ERASE: begin
                           phase_q <= PH_ARG;
                        end
                        default: begin
                           phase_q <= PH_IGNORE;
                        end
                     endcase
                  end
               end
            end
            PH_ARG: begin
               shiftIn_q <= opcNow;
               bitCnt_q  <= bitCnt_q + 3'h1;
               if (bitCnt_q == 3'h7) begin
                  phase_q <= PH_IGNORE;
               end
            end
            PH_QUAD_IN: begin
               shiftIn_q <= {shiftIn_q[3:0], laneIn};  // [RULE_06]
               bitCnt_q  <= bitCnt_q + 3'h4;
            end
            PH_OUT, PH_IGNORE: begin
               bitCnt_q <= bitCnt_q;
            end
            default: begin
               phase_q <= PH_IGNORE;
            end
         endcase
      end
   end

   // request latch; survives deselect for the core
   always_ff @(posedge sclk or posedge srst) begin
      if (srst) begin
         req_q <= '0;
      end else if (!selectN && !pausedRise) begin
         if (!started_q) begin
            req_q.valid <= 1'b0;  // new frame voids the old request [RULE_23]
         end else if (argDone) begin
            req_q <= '{valid: 1'b1, code: code_q, arg: argByte};
         end
      end
   end

   // output step, lane mask and next output byte
   always_comb begin
      case (width_q)
         LW_TWO: begin
            outStep = 3'h2;
            outMask = 4'b0011;
         end
         LW_FOUR: begin
            outStep = 3'h4;
            outMask = 4'b1111;
         end
         default: begin
            outStep = 3'h1;
            outMask = 4'b0010;  // serial_out only [RULE_05] [RULE_07]
         end
      endcase
      if (outCnt_q == 3'h0) begin
         outNext = srcBuf_q ? cfgL.buffer : cfgL.status;
      end else begin
         outNext = outShift_q << outStep;
      end
      case (width_q)
         LW_TWO:  outLanes = {2'b00, outNext[7:6]};
         LW_FOUR: outLanes = outNext[7:4];
         default: outLanes = {2'b00, outNext[7], 1'b0};
      endcase
   end

   // output data on the falling edge, frozen while paused
   always_ff @(negedge sclk or posedge frameRst) begin
      if (frameRst) begin
         outShift_q <= 8'h00;
         outCnt_q   <= 3'h0;
         laneOut    <= 4'h0;
      end else if (!pauseAtRise && phase_q == PH_OUT) begin  // [RULE_16]
         outShift_q <= outNext;                               // [RULE_05] [RULE_06]
         outCnt_q   <= outCnt_q + outStep;
         laneOut    <= outLanes;
      end
   end

   // enables: forced off by deselect or pause, else set on the fall
   always_ff @(negedge sclk or posedge floatNow) begin
      if (floatNow) begin
         laneOeN <= 4'hF;                    // [RULE_01] [RULE_15]
      end else if (!pauseAtRise && phase_q == PH_OUT) begin
         laneOeN <= ~outMask;                // [RULE_07]
      end else begin
         laneOeN <= 4'hF;
      end
   end

   // pins and request cross through two flops
   snp_sync #(.WIDTH(2)) u_pin_sync (
      .clk  (clk),
      .rst  (srst),
      .din  ({selectN, laneIn[2]}),
      .dout (pinSync)
   );
   assign selS   = pinSync[1];
   assign guardS = pinSync[0];

   snp_sync #(.WIDTH($bits(snp_req_s))) u_req_sync (
      .clk  (clk),
      .rst  (srst),
      .din  (req_q),
      .dout (reqS)
   );

   // field views of the protection register
   assign guardMode  = protectionReg[PROT_GUARD_MODE_BIT];
   assign blockBits  = protectionReg[PROT_BLOCK_LSB +: 4];
   assign lockBit    = protectionReg[PROT_LOCK_LSB];
   // guarded span: one top block up to the whole array
   assign guardCount = (blockBits == 4'h0) ? 9'h000 :
                       (blockBits > 4'h8)  ? BLOCK_COUNT :
                       (9'h001 << (blockBits - 4'h1));
   assign inRegion   = {1'b0, reqS.arg} >= (BLOCK_COUNT - guardCount);  // [RULE_14]

   // a request runs as select is released
   assign execute = ~selPrev_q & selS & armed_q & reqS.valid;

   // protection check per request
   always_comb begin
      accept = 1'b0;
      opLen  = BUSY_W'(PROGRAM_CYCLES);
      case (reqS.code)
         OPC_WRITE_PROT: begin
            if (guardMode) begin
               accept = ~opBusy & guardS;            // [RULE_11] [RULE_12]
            end else begin
               accept = ~opBusy & ~(~guardS & lockBit);  // [RULE_09] [RULE_10] [RULE_14]
            end
         end
         OPC_PROGRAM: begin
            accept = ~opBusy & ~(guardMode & ~guardS) & ~inRegion;  // [RULE_12] [RULE_14]
         end
         OPC_ERASE: begin
            accept = ~opBusy & ~(guardMode & ~guardS) & ~inRegion;  // [RULE_12] [RULE_14]
            opLen  = BUSY_W'(ERASE_CYCLES);
         end
         OPC_QUAD_LOAD: begin
            accept = ~guardMode;                     // [RULE_11]
         end
         default: begin
            accept = 1'b0;
         end
      endcase
   end
   assign startOp = execute & accept & (reqS.code == OPC_PROGRAM || reqS.code == OPC_ERASE);

   // arming on the first select fall
   always_ff @(posedge clk) begin
      if (srst) begin
         selPrev_q <= 1'b0;
         armed_q   <= 1'b0;
      end else begin
         selPrev_q <= selS;
         if (selPrev_q && !selS) begin
            armed_q <= 1'b1;                         // [RULE_03]
         end
      end
   end

   // internal operation timer, blind to select
   always_ff @(posedge clk) begin
      if (srst) begin
         opBusy    <= 1'b0;
         busyCnt_q <= '0;
      end else if (startOp) begin
         opBusy    <= 1'b1;
         busyCnt_q <= opLen - BUSY_W'(1);
      end else if (opBusy) begin
         if (busyCnt_q == '0) begin
            opBusy <= 1'b0;
         end else begin
            busyCnt_q <= busyCnt_q - BUSY_W'(1);     // [RULE_02]
         end
      end
   end

   // register, buffer and refusal flag
   always_ff @(posedge clk) begin
      if (srst) begin
         protectionReg <= PROT_RESET;
         buffer_q      <= 8'h00;
         cmdRejected   <= 1'b0;
      end else if (execute) begin
         cmdRejected <= ~accept;
         if (accept && reqS.code == OPC_WRITE_PROT) begin
            protectionReg <= reqS.arg;
         end
         if (accept && reqS.code == OPC_QUAD_LOAD) begin
            buffer_q <= reqS.arg;
         end
      end
   end

   // state shown to the link side
   assign cfgC = '{armed: armed_q, guardMode: guardMode,
                   status: {opBusy, cmdRejected, protectionReg[7:2]}, buffer: buffer_q};

endmodule

/* verification/snp_props.sv */
// assertions on the pin interface ports
// assumes sclk runs far slower than clk
`timescale 1ns/1ps
module snp_props
   import snp_pkg::*;
(
   input wire logic       clk,           // core clock
   input wire logic       srst,          // sync reset
   input wire logic       sclk,          // serial clock
   input wire logic       selectN,       // select, active low
   input wire logic [3:0] laneIn,        // pin levels
   input wire logic [3:0] laneOut,       // lane values
   input wire logic [3:0] laneOeN,       // lane enables
   input wire logic       opBusy,        // operation running
   input wire logic [7:0] protectionReg, // protection register
   input wire logic       cmdRejected    // refusal flag
);
   logic [11:0] busyCnt_q; // cycles of the current busy run
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   // length of the current busy run
   always_ff @(posedge clk) begin
      if (srst || !opBusy) begin
         busyCnt_q <= 12'h000;
      end else begin
         busyCnt_q <= busyCnt_q + 12'h001;
      end
   end
   float_deselect_a: assert property (selectN |-> laneOeN == 4'hF)
      else $error("lane driven while deselected");
   busy_length_a: assert property (
      $fell(opBusy) |-> busyCnt_q == PROGRAM_CYCLES || busyCnt_q == ERASE_CYCLES)
      else $error("busy run of wrong length");
   lane_sets_a: assert property (laneOeN inside {4'hF, 4'hD, 4'hC, 4'h0})
      else $error("illegal lane set");
   out_on_fall_a: assert property (!$stable(laneOut) |-> !sclk || selectN)
      else $error("data moved off falling clock");
   oe_on_fall_a: assert property (!$stable(laneOeN) |-> !sclk || selectN)
      else $error("enable moved off falling clock");
   quad_blocked_a: assert property (protectionReg[7] |-> laneOeN != 4'h0)
      else $error("quad read in guard pin mode");
   pause_float_a: assert property (
      (!selectN && !laneIn[3] && !sclk && laneOeN != 4'h0) [*2] |-> laneOeN[1])
      else $error("output driven in pause");
   hw_guard_a: assert property (
      (protectionReg[7] && !laneIn[2]) [*4] |=> $stable(protectionReg) && !$rose(opBusy))
      else $error("write accepted under guard");
   exec_deselect_a: assert property (
      $rose(opBusy) || !$stable(protectionReg) || !$stable(cmdRejected) |-> selectN)
      else $error("command run while selected");
endmodule
bind snp_nand_if snp_props u_snp_props (.clk(clk), .srst(srst), .sclk(sclk), .selectN(selectN),
   .laneIn(laneIn), .laneOut(laneOut), .laneOeN(laneOeN), .opBusy(opBusy),
   .protectionReg(protectionReg), .cmdRejected(cmdRejected));

/* verification/snp_host_model.sv */
// host model: clock, select, lane drive
// assumes the bench resolves lanes from the enables
`timescale 1ns/1ps
module snp_host_model (
   output logic            sclk,     // serial clock, still between frames
   output logic            selectN,  // select, active low
   output logic [3:0]      hostLane, // host drive, pull-ups on 2 and 3
   input  wire logic [3:0] laneIn    // resolved pin levels
);
   logic       idle;   // idle clock level, 1 in mode 3
   logic       guardN; // guard level asked by the bench
   logic [3:0] seen;   // levels taken at the last rise
   initial begin
      sclk = 1'b0;
      selectN = 1'b0; // low from power-up: no falling edge yet
      hostLane = 4'hC;
      idle = 1'b0;
      guardN = 1'b1;
      seen = 4'h0;
   end
   // lanes change with clock low, sampled at the rise
   task automatic tick(input logic [3:0] drv);
      sclk <= 1'b0;
      hostLane <= drv;
      #40;
      seen = laneIn;
      sclk <= 1'b1;
      #40;
   endtask
   // clock rests at its mode level over select edges
   task automatic open_frame(input logic mode3);
      idle = mode3;
      sclk <= mode3;
      #30 selectN <= 1'b0;
      #30;
   endtask
   task automatic close_frame();
      sclk <= idle;
      #30 selectN <= 1'b1;
      #100;
   endtask
   // msb first, pause pin held high, released lane1 inverted
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         tick({1'b1, guardN, ~seen[1], b[i]});
      end
   endtask
   task automatic send_quad(input logic [7:0] b);
      tick(b[7:4]);
      tick(b[3:0]);
   endtask
   // w lanes a bit time; released lanes 0 and 1 show the inverse level
   task automatic read_bits(input int w, output logic [7:0] d);
      d = 8'h00;
      for (int k = 0; k < 8 / w; k++) begin
         tick({1'b1, guardN, ~seen[1:0]});
         d = (w == 1) ? {d[6:0], seen[1]} : (w == 2) ? {d[5:0], seen[1:0]} : {d[3:0], seen};
      end
   endtask
   // pause and resume with clock low, select held
   task automatic pause_gap();
      sclk <= 1'b0;
      #20 hostLane[3] <= 1'b0;
      #20;
      tick({1'b0, guardN, 2'b11});
      tick({1'b0, guardN, 2'b11});
      sclk <= 1'b0;
      #20 hostLane[3] <= 1'b1;
      #20;
   endtask
endmodule

/* verification/tb_top.sv */
// bench: host model on the link, checks at ports
// assumes link edges stay off core clock edges
`timescale 1ns/1ps
module tb_top;
   import snp_pkg::*;
   logic       clk, srst, sclk, selectN, opBusy, cmdRejected; // design ports
   logic [3:0] hostLane, laneIn, laneOut, laneOeN;            // lane signals
   logic [7:0] protectionReg, expProt, got;                   // register, expectation, read data
   logic       expRej;                                        // expected refusal
   int         failures, compares;                            // counters
   // device where it drives, else host
   assign laneIn = (laneOut & ~laneOeN) | (hostLane & laneOeN);
   snp_nand_if u_snp_nand_if (.clk(clk), .srst(srst), .sclk(sclk), .selectN(selectN), .laneIn(laneIn),
      .laneOut(laneOut), .laneOeN(laneOeN), .opBusy(opBusy), .protectionReg(protectionReg),
      .cmdRejected(cmdRejected));
   snp_host_model hm (.sclk(sclk), .selectN(selectN), .hostLane(hostLane), .laneIn(laneIn));
   initial clk = 1'b0;
   always #2 clk = ~clk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // bounded busy wait; fraction keeps off clk edges
   task automatic wait_idle();
      for (int n = 0; n < 400 && opBusy === 1'b1; n++) begin
         @(posedge clk);
      end
      if (opBusy !== 1'b0) begin
         failures++;
         report_and_stop();
      end
      #0.3;
   endtask
   // read that must float
   task automatic t_silent(input logic doOpen, input logic [7:0] op);
      if (doOpen) begin
         hm.open_frame(1'b0);
      end
      hm.send_bits(op, 8);
      hm.read_bits(4, got);
      check({4'h0, laneOeN}, 8'h0F);
      hm.close_frame();
   endtask
   // status read, pause optional
   task automatic t_status(input logic mode3, input logic withPause);
      hm.open_frame(mode3);
      hm.send_bits(OPC_READ_STATUS, withPause ? 4 : 8);
      if (withPause) begin
         hm.pause_gap();
         hm.send_bits({OPC_READ_STATUS[3:0], 4'h0}, 4);
      end
      hm.read_bits(1, got);
      hm.close_frame();
      check(got, {1'b0, expRej, expProt[7:2]});
   endtask
   // five bits of an erase opcode: nothing starts
   task automatic t_partial(input logic mode3);
      hm.open_frame(mode3);
      hm.send_bits(OPC_ERASE, 5);
      hm.close_frame();
      check({7'h00, opBusy}, 8'h00);
   endtask
   // one-argument command at a guard level
   task automatic t_cmd(input logic [7:0] op, input logic [7:0] arg, input logic g, input logic ok);
      hm.guardN = g;
      hm.open_frame(1'b0);
      hm.send_bits(op, 8);
      hm.send_bits(arg, 8);
      hm.close_frame();
      expRej = !ok;
      expProt = (op == OPC_WRITE_PROT && ok) ? arg : expProt;
      check(protectionReg, expProt);
      check({7'h00, cmdRejected}, {7'h00, expRej});
      if (op != OPC_WRITE_PROT) begin
         check({7'h00, opBusy}, {7'h00, ok});
         wait_idle();
      end
   endtask
   // quad load, then dual and quad reads
   task automatic t_lanes(input logic [7:0] a, input logic [7:0] b);
      hm.open_frame(1'b0);
      hm.send_bits(OPC_QUAD_LOAD, 8);
      hm.send_quad(a);
      hm.send_quad(b);
      hm.close_frame();
      expRej = 1'b0;
      for (int w = 2; w <= 4; w += 2) begin
         hm.open_frame(1'b0);
         hm.send_bits((w == 2) ? OPC_DUAL_READ : OPC_QUAD_READ, 8);
         hm.read_bits(w, got);
         check({4'h0, laneOeN}, (w == 2) ? 8'h0C : 8'h00);
         hm.close_frame();
         check(got, b);
      end
   endtask
   initial begin
      srst = 1'b1;
      failures = 0;
      compares = 0;
      expProt = PROT_RESET;
      expRej = 1'b0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      #0.3;
      t_silent(1'b0, OPC_READ_STATUS);
      t_status(1'b0, 1'b0);
      t_partial(1'b1);
      t_cmd(OPC_WRITE_PROT, 8'h0A, 1'b1, 1'b1);
      t_cmd(OPC_WRITE_PROT, 8'h00, 1'b0, 1'b0);
      t_status(1'b1, 1'b0);
      t_cmd(OPC_PROGRAM, 8'hFF, 1'b1, 1'b0);
      t_cmd(OPC_PROGRAM, 8'hFE, 1'b1, 1'b1);
      t_cmd(OPC_ERASE, 8'hFE, 1'b1, 1'b1);
      t_status(1'b0, 1'b1);
      t_lanes(8'hA5, 8'h3C);
      t_cmd(OPC_WRITE_PROT, 8'h80, 1'b1, 1'b1);
      t_silent(1'b1, OPC_QUAD_READ);
      t_cmd(OPC_ERASE, 8'h00, 1'b0, 1'b0);
      t_cmd(OPC_WRITE_PROT, 8'h00, 1'b0, 1'b0);
      t_cmd(OPC_WRITE_PROT, 8'h00, 1'b1, 1'b1);
      report_and_stop();
   end
endmodule
